// ---- src/rsq_consts.vh ----
// Constants for the string-repeat prefix sequencer.
// Assumes inclusion by bare name from each design file.
`ifndef RSQ_CONSTS_VH
`define RSQ_CONSTS_VH

// Width of the repeat count register
`define RSQ_CNT_W      16
`define RSQ_CNT_ZERO   16'h0000
`define RSQ_CNT_ONE    16'h0001

// Prefix bytes; the equal and zero forms share the plain repeat byte
`define RSQ_PFX_REP    8'hF3
`define RSQ_PFX_NE     8'hF2

// String primitive opcodes, byte form; word form sets the low bit
`define RSQ_OP_MOVE    8'hA4
`define RSQ_OP_CMP     8'hA6
`define RSQ_OP_STORE   8'hAA
`define RSQ_OP_SCAN    8'hAE
`define RSQ_OP_SZ_MASK 8'hFE

// Opcode register value out of reset
`define RSQ_OP_RST     8'h00

// Sequencer states
`define RSQ_ST_IDLE    3'h0
`define RSQ_ST_PFX     3'h1
`define RSQ_ST_CHK     3'h2
`define RSQ_ST_IRQ     3'h3
`define RSQ_ST_RUN     3'h4
`define RSQ_ST_TST     3'h5
`define RSQ_ST_FIN     3'h6

`endif

// ---- src/rsq_count.v ----
// Repeat count register with load and decrement.
// Assumes load and decrement are never asked for in the same cycle.
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.vh"

module rsq_count #(
  parameter CNT_W = `RSQ_CNT_W
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  // Control
  input  wire             load_i,
  input  wire [CNT_W-1:0] load_val_i,
  input  wire             dec_i,
  // State
  output reg  [CNT_W-1:0] count_o
);

  // Load wins over decrement
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      count_o <= {CNT_W{1'b0}};
    end else if (load_i) begin
      count_o <= load_val_i;
    end else if (dec_i) begin
      count_o <= count_o - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

endmodule
`default_nettype wire

// ---- src/rsq_seq.v ----
// String-repeat prefix sequencer: decodes prefix and string bytes and
// runs the repeat loop. Assumes the core executes one primitive per
// start pulse and answers with a done pulse carrying the zero flag.
`timescale 1ns/100ps
`default_nettype none
`include "rsq_consts.vh"

// Operation
// - A plain repeat on a move or store keeps running while the count is not zero.
// - Each repetition first services any pending interrupt before the primitive runs.
// - After each pass the count drops by one and is tested for zero before the next pass.
// - The repeat, while-equal and while-zero forms are one and the same prefix byte.
// - The equal form on compare or scan repeats only if the primitive left the flag set.
// - The not-equal form on compare or scan stops as soon as the primitive sets the flag.
// - The not-equal form ignores the flag value held before the first pass.
module rsq_seq #(
  parameter CNT_W = `RSQ_CNT_W
) (
  // Clock and reset
  input  wire             sys_clk_i,
  input  wire             rst_n_i,
  // Instruction byte stream
  input  wire             op_valid_i,
  input  wire [7:0]       op_byte_i,
  output reg              op_ready_o,
  // Count register load
  input  wire             count_load_i,
  input  wire [CNT_W-1:0] count_load_val_i,
  output wire [CNT_W-1:0] count_o,
  // Interrupt service
  input  wire             irq_pending_i,
  input  wire             irq_ack_i,
  output reg              irq_service_o,
  // Primitive execution
  output reg              prim_start_o,
  output reg  [7:0]       prim_op_o,
  input  wire             prim_done_i,
  input  wire             zero_flag_i,
  // Status
  output reg              rep_active_o,
  output reg              done_o
);

  reg  [2:0]       state_r;
  reg  [2:0]       state_nxt;
  reg              ne_r;
  reg              ne_nxt;
  reg              cmp_r;
  reg              cmp_nxt;
  reg              zf_r;
  reg              zf_nxt;
  reg  [7:0]       op_nxt;
  reg              rep_nxt;
  reg              start_nxt;
  reg              done_nxt;
  reg              dec;
  wire             take;
  wire             load;
  wire             cnt_zero;

  // Primitive class of a byte, both sizes
  function is_string;
    input [7:0] b;
    reg   [7:0] m;
    begin
      m = b & `RSQ_OP_SZ_MASK;
      is_string = (m == `RSQ_OP_MOVE) || (m == `RSQ_OP_STORE) ||
                  (m == `RSQ_OP_CMP) || (m == `RSQ_OP_SCAN);
    end
  endfunction

  function is_cmp_scan;
    input [7:0] b;
    reg   [7:0] m;
    begin
      m = b & `RSQ_OP_SZ_MASK;
      is_cmp_scan = (m == `RSQ_OP_CMP) || (m == `RSQ_OP_SCAN);
    end
  endfunction

  // Prefix detection; one byte covers three forms
  function is_prefix;
    input [7:0] b;
    begin
      is_prefix = (b == `RSQ_PFX_REP) || (b == `RSQ_PFX_NE);
    end
  endfunction

  assign take     = op_valid_i && op_ready_o;
  assign load     = count_load_i && (state_r == `RSQ_ST_IDLE);
  assign cnt_zero = (count_o == `RSQ_CNT_ZERO);

  // Count register
  rsq_count #(
    .CNT_W      (CNT_W)
  ) u_count (
    .sys_clk_i  (sys_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (load),
    .load_val_i (count_load_val_i),
    .dec_i      (dec),
    .count_o    (count_o)
  );

  // Next-state logic
  always @* begin
    state_nxt = state_r;
    ne_nxt    = ne_r;
    cmp_nxt   = cmp_r;
    zf_nxt    = zf_r;
    op_nxt    = prim_op_o;
    rep_nxt   = rep_active_o;
    start_nxt = 1'b0;
    done_nxt  = 1'b0;
    dec       = 1'b0;
    case (state_r)
      `RSQ_ST_IDLE: begin
        if (take) begin
          if (is_prefix(op_byte_i)) begin
            ne_nxt    = (op_byte_i == `RSQ_PFX_NE);
            state_nxt = `RSQ_ST_PFX;
          end else begin
            // Unprefixed instruction runs once
            op_nxt    = op_byte_i;
            rep_nxt   = 1'b0;
            start_nxt = 1'b1;
            state_nxt = `RSQ_ST_RUN;
          end
        end
      end
      `RSQ_ST_PFX: begin
        if (take) begin
          if (is_prefix(op_byte_i)) begin
            ne_nxt = (op_byte_i == `RSQ_PFX_NE); // Last prefix counts
          end else if (is_string(op_byte_i)) begin
            op_nxt    = op_byte_i;
            cmp_nxt   = is_cmp_scan(op_byte_i);
            rep_nxt   = 1'b1;
            state_nxt = `RSQ_ST_CHK;
          end else begin
            // Prefix has no effect on a non-string instruction
            op_nxt    = op_byte_i;
            rep_nxt   = 1'b0;
            start_nxt = 1'b1;
            state_nxt = `RSQ_ST_RUN;
          end
        end
      end
      `RSQ_ST_CHK: begin
        if (cnt_zero) begin
          state_nxt = `RSQ_ST_FIN;
        end else if (irq_pending_i) begin
          state_nxt = `RSQ_ST_IRQ;
        end else begin
          start_nxt = 1'b1;
          state_nxt = `RSQ_ST_RUN;
        end
      end
      `RSQ_ST_IRQ: begin
        if (irq_ack_i) begin
          start_nxt = 1'b1;
          state_nxt = `RSQ_ST_RUN;
        end
      end
      `RSQ_ST_RUN: begin
        if (prim_done_i) begin
          if (rep_active_o) begin
            dec       = 1'b1;
            zf_nxt    = zero_flag_i;
            state_nxt = `RSQ_ST_TST;
          end else begin
            state_nxt = `RSQ_ST_FIN;
          end
        end
      end
      `RSQ_ST_TST: begin
        // Flag exit only for compare and scan, taken from this pass
        if (cmp_r && (ne_r ? zf_r : !zf_r)) begin
          state_nxt = `RSQ_ST_FIN;
        end else begin
          state_nxt = `RSQ_ST_CHK;
        end
      end
      `RSQ_ST_FIN: begin
        done_nxt  = 1'b1;
        rep_nxt   = 1'b0;
        state_nxt = `RSQ_ST_IDLE;
      end
      default: begin
        state_nxt = `RSQ_ST_IDLE;
      end
    endcase
  end

  // State and output registers
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_r       <= `RSQ_ST_IDLE;
      ne_r          <= 1'b0;
      cmp_r         <= 1'b0;
      zf_r          <= 1'b0;
      prim_op_o     <= `RSQ_OP_RST;
      rep_active_o  <= 1'b0;
      prim_start_o  <= 1'b0;
      done_o        <= 1'b0;
      op_ready_o    <= 1'b0;
      irq_service_o <= 1'b0;
    end else begin
      state_r       <= state_nxt;
      ne_r          <= ne_nxt;
      cmp_r         <= cmp_nxt;
      zf_r          <= zf_nxt;
      prim_op_o     <= op_nxt;
      rep_active_o  <= rep_nxt;
      prim_start_o  <= start_nxt;
      done_o        <= done_nxt;
      op_ready_o    <= (state_nxt == `RSQ_ST_IDLE) || (state_nxt == `RSQ_ST_PFX);
      irq_service_o <= (state_nxt == `RSQ_ST_IRQ);
    end
  end

endmodule
`default_nettype wire

// ---- verif/rsq_seq_checker.sv ----
// Port checker for the repeat sequencer.
// Assumes a bind onto rsq_seq, one clock domain.
`timescale 1ns/100ps
`default_nettype none
module rsq_seq_checker #(
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire logic             sys_clk_i,
  input wire logic             rst_n_i,
  // Sequencer inputs
  input wire logic             irq_pending_i,
  input wire logic             irq_ack_i,
  input wire logic             prim_done_i,
  // Sequencer outputs
  input wire logic             op_ready_o,
  input wire logic             irq_service_o,
  input wire logic             prim_start_o,
  input wire logic             rep_active_o,
  input wire logic             done_o,
  input wire logic [7:0]       prim_op_o,
  input wire logic [CNT_W-1:0] count_o
);
  logic run_q;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // Primitive in flight from start pulse to done; a stray done is not counted
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      run_q <= 1'b0;
    end else if (prim_done_i) begin
      run_q <= 1'b0;
    end else if (prim_start_o) begin
      run_q <= 1'b1;
    end
  end
  wire in_run = prim_start_o || run_q;
  // Move or store, either size
  wire mvst = (prim_op_o & 8'hFE) == 8'hA4 || (prim_op_o & 8'hFE) == 8'hAA;
  AST_DEC: assert property (
    in_run && prim_done_i && rep_active_o |=> count_o == $past(count_o) - 1'b1)
    else $error("count missed a decrement");
  AST_ZSTOP: assert property (
    rep_active_o && count_o == 0 |-> !prim_start_o)
    else $error("pass started at zero count");
  AST_GO: assert property (
    in_run && prim_done_i && rep_active_o && mvst && count_o > 1 ##2 !irq_pending_i
    |-> ##1 prim_start_o)
    else $error("move or store did not repeat");
  AST_IRQGO: assert property (
    irq_service_o && irq_ack_i |=> prim_start_o && !irq_service_o)
    else $error("no pass after service");
  AST_IRQHOLD: assert property (
    irq_service_o && !irq_ack_i |=> irq_service_o && !prim_start_o)
    else $error("pass ran during service");
  AST_END: assert property (
    $fell(rep_active_o) |-> done_o && op_ready_o)
    else $error("loop end without done");
  AST_PULSE: assert property (
    done_o |=> !done_o)
    else $error("done longer than a cycle");
  AST_BUSY: assert property (
    rep_active_o |-> !op_ready_o)
    else $error("byte taken during loop");
  AST_ONESHOT: assert property (
    prim_start_o |=> !prim_start_o)
    else $error("start longer than a cycle");
  AST_OPHOLD: assert property (
    rep_active_o && $past(rep_active_o) |-> $stable(prim_op_o))
    else $error("opcode changed during loop");
  C_IRQ: cover property (irq_service_o && irq_ack_i);
  C_END: cover property ($fell(rep_active_o));
  C_DEC: cover property (prim_done_i && rep_active_o);
endmodule
bind rsq_seq rsq_seq_checker #(.CNT_W(CNT_W)) u_chk (
  .sys_clk_i     (sys_clk_i),
  .rst_n_i       (rst_n_i),
  .irq_pending_i (irq_pending_i),
  .irq_ack_i     (irq_ack_i),
  .prim_done_i   (prim_done_i),
  .op_ready_o    (op_ready_o),
  .irq_service_o (irq_service_o),
  .prim_start_o  (prim_start_o),
  .rep_active_o  (rep_active_o),
  .done_o        (done_o),
  .prim_op_o     (prim_op_o),
  .count_o       (count_o)
);
`default_nettype wire

// ---- verif/string_repeat_prefix_sequencer_tb.sv ----
// Self-checking bench for the repeat sequencer.
// Assumes rsq_seq with a 250 MHz clock.
`timescale 1ns/100ps
`default_nettype none
module string_repeat_prefix_sequencer_tb;
  logic sys_clk_i, rst_n_i, op_valid_i, count_load_i, irq_pending_i, irq_ack_i;
  logic prim_done_i, zero_flag_i, op_ready_o, irq_service_o, prim_start_o;
  logic rep_active_o, done_o;
  logic [7:0] op_byte_i, prim_op_o, zf;
  logic [15:0] count_load_val_i, count_o;
  int n_fail, checks;
  int npass = 0, nirq = 0, cyc = 0, pidx = 0;
  rsq_seq dut (
    .sys_clk_i        (sys_clk_i),
    .rst_n_i          (rst_n_i),
    .op_valid_i       (op_valid_i),
    .op_byte_i        (op_byte_i),
    .op_ready_o       (op_ready_o),
    .count_load_i     (count_load_i),
    .count_load_val_i (count_load_val_i),
    .count_o          (count_o),
    .irq_pending_i    (irq_pending_i),
    .irq_ack_i        (irq_ack_i),
    .irq_service_o    (irq_service_o),
    .prim_start_o     (prim_start_o),
    .prim_op_o        (prim_op_o),
    .prim_done_i      (prim_done_i),
    .zero_flag_i      (zero_flag_i),
    .rep_active_o     (rep_active_o),
    .done_o           (done_o)
  );
  // Clock
  initial begin
    sys_clk_i = 1'b0;
    forever #2 sys_clk_i = ~sys_clk_i;
  end
  // Core stand-in: done a cycle after start, flag set outside done
  always @(posedge sys_clk_i) begin
    prim_done_i <= prim_start_o;
    zero_flag_i <= prim_start_o ? zf[pidx] : 1'b1;
    // Pass index restarts at each done pulse, total count runs on
    if (prim_start_o) begin
      npass <= npass + 1;
      pidx <= pidx + 1;
    end else if (done_o) begin
      pidx <= 0;
    end
    irq_ack_i <= irq_service_o & ~irq_ack_i;
    if (irq_service_o & irq_ack_i) nirq <= nirq + 1;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      wrap_up();
    end
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Offer one byte until taken
  task send(input logic [7:0] b);
    op_valid_i <= 1'b1;
    op_byte_i <= b;
    @(negedge sys_clk_i);
    while (!op_ready_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
  endtask
  // Load count, send up to two prefixes and op, check passes, count and services
  task run(input logic [15:0] p, input logic [7:0] op, input logic [15:0] c,
           input logic [7:0] f, input int ep, input logic [15:0] ec, input int ei);
    int n;
    int bp;
    int bi;
    bp = npass;
    bi = nirq;
    zf <= f;
    count_load_i <= 1'b1;
    count_load_val_i <= c;
    @(posedge sys_clk_i);
    count_load_i <= 1'b0;
    if (p[15:8] != 8'h00) send(p[15:8]);
    if (p[7:0] != 8'h00) send(p[7:0]);
    send(op);
    op_valid_i <= 1'b0;
    n = 0;
    // Wait for the done pulse, then compare while it stands
    while (!done_o && n < 300) begin
      @(negedge sys_clk_i);
      n++;
    end
    chk({12'h000, irq_service_o, rep_active_o, op_ready_o, done_o}, 16'h0003);
    chk({8'h00, prim_op_o}, {8'h00, op});
    chk(16'(npass - bp), 16'(ep));
    chk(count_o, ec);
    chk(16'(nirq - bi), 16'(ei));
    @(posedge sys_clk_i);
  endtask
  task t_move;
    run(8'hF3, 8'hA4, 16'h0003, 8'h00, 3, 16'h0000, 0);
    run(8'hF3, 8'hAA, 16'h0000, 8'h00, 0, 16'h0000, 0);
    run(8'hF3, 8'hAB, 16'h0001, 8'h00, 1, 16'h0000, 0);
    $display("test move done");
  endtask
  task t_eq;
    run(8'hF3, 8'hA6, 16'h0005, 8'hFB, 3, 16'h0002, 0);
    run(8'hF3, 8'hAF, 16'h0003, 8'hFF, 3, 16'h0000, 0);
    $display("test equal done");
  endtask
  task t_ne;
    run(8'hF2, 8'hAE, 16'h0005, 8'h04, 3, 16'h0002, 0);
    run(8'hF2, 8'hA7, 16'h0002, 8'h00, 2, 16'h0000, 0);
    $display("test not equal done");
  endtask
  task t_irq;
    irq_pending_i <= 1'b1;
    run(8'hF3, 8'hA5, 16'h0002, 8'h00, 2, 16'h0000, 2);
    irq_pending_i <= 1'b0;
    $display("test interrupt done");
  endtask
  task t_pfx;
    run(8'hF3, 8'h90, 16'h0004, 8'h00, 1, 16'h0004, 0);
    run(8'h00, 8'hA4, 16'h0004, 8'h00, 1, 16'h0004, 0);
    run(16'hF3F2, 8'hAE, 16'h0005, 8'h04, 3, 16'h0002, 0);
    run(16'hF2F3, 8'hA6, 16'h0005, 8'hFB, 3, 16'h0002, 0);
    $display("test prefix scope done");
  endtask
  task wrap_up;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    {rst_n_i, op_valid_i, count_load_i, irq_pending_i} = 4'h0;
    {op_byte_i, count_load_val_i, zf} = 32'h0;
    {n_fail, checks} = 64'h0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    t_move();
    t_eq();
    t_ne();
    t_irq();
    t_pfx();
    wrap_up();
  end
endmodule
`default_nettype wire
